// file: inc/prs_map.svh
`ifndef PRS_MAP_SVH
`define PRS_MAP_SVH
// Register offsets of the keypad parameter port.
`define PRS_ADDR_CTRL       8'h00
`define PRS_ADDR_ACCEL      8'h01
`define PRS_ADDR_DECEL      8'h02
`define PRS_ADDR_MINFREQ    8'h03
`define PRS_ADDR_MAXFREQ    8'h04
`define PRS_ADDR_SETPOINT   8'h05
`define PRS_ADDR_SLEEPOFS   8'h06
`define PRS_ADDR_FORCEOFS   8'h07
`define PRS_ADDR_WAKETHR    8'h08
`define PRS_ADDR_RAISE      8'h09
`define PRS_ADDR_TOFF       8'h0A
`define PRS_ADDR_LONGON     8'h0B
`define PRS_ADDR_SHORTON    8'h0C
`define PRS_ADDR_TORQUE     8'h0D
`define PRS_ADDR_FLUX       8'h0E
`define PRS_ADDR_STATUS     8'h10
`define PRS_ADDR_FREQ       8'h11
`define PRS_ADDR_TARGET     8'h12
// Control register bit positions.
`define PRS_CTRL_SUBMERSIBLE 0
`define PRS_CTRL_FREEWHEEL   1
`define PRS_CTRL_VECTOR      2
`define PRS_CTRL_RUN         3
// Reset values; frequencies in 0.1 Hz, pressure in psi, times in seconds.
`define PRS_RST_ACCEL_S     16'h000C
`define PRS_RST_MINFREQ     16'h012C
`define PRS_RST_MAXFREQ     16'h0258
`define PRS_RST_SETPOINT    16'h0032
`define PRS_RST_SLEEPOFS    16'h0000
`define PRS_RST_FORCEOFS    16'h0014
`define PRS_RST_WAKETHR     16'h0005
`define PRS_RST_RAISE       16'h0005
`define PRS_RST_TOFF        16'h003C
`define PRS_RST_LONGON      16'h003C
`define PRS_RST_SHORTON     16'h000A
`define PRS_RST_TORQUE      16'h0064
`define PRS_RST_FLUX        16'h0064
`define PRS_RST_CTRL        16'h0001
// Flux scaling limits in percent.
`define PRS_FLUX_MIN        16'h000A
`define PRS_FLUX_MAX        16'h00C8
// Timing: clock rate and the one-second fast climb.
`define PRS_CLK_HZ          50000000
`define PRS_FAST_CLIMB_MS   1000
`define PRS_CYC_PER_SEC     (`PRS_CLK_HZ)
`define PRS_FAST_CLIMB_CYC  ((`PRS_CLK_HZ / 1000) * `PRS_FAST_CLIMB_MS)
`endif

// file: inc/prs_pkg.sv
package prs_pkg;
  typedef enum logic [1:0] {
    PRS_ST_STOP  = 2'b00,
    PRS_ST_RUN   = 2'b01,
    PRS_ST_BOOST = 2'b11,
    PRS_ST_SLEEP = 2'b10
  } prs_state_type;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } prs_bus_req_type;

  typedef struct packed {
    logic [15:0] freq_cmd;
    logic [15:0] torque_lim;
    logic [15:0] flux_scale;
    logic        vector_mode;
  } prs_drive_type;
endpackage

// file: hw/prs_sec_timer.sv
`timescale 1ns/10ps
`include "prs_map.svh"
// Seconds counter with a synchronous restart; saturates at full scale.
module prs_sec_timer import prs_pkg::*; #(
  parameter int CYC_PER_SEC = `PRS_CYC_PER_SEC
) (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Control and count.
  input  wire logic        restart,
  input  wire logic        enable,
  output logic [15:0]      seconds
);
  initial begin
    if (CYC_PER_SEC < 2) $error("CYC_PER_SEC too small");
  end

  logic [31:0] tick_reg;

  // Prescaler and seconds count; restart clears both.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tick_reg <= 32'h0000_0000;
      seconds  <= 16'h0000;
    end else if (restart) begin
      tick_reg <= 32'h0000_0000;
      seconds  <= 16'h0000;
    end else if (enable) begin
      if (tick_reg == 32'(CYC_PER_SEC - 1)) begin
        tick_reg <= 32'h0000_0000;
        if (seconds != 16'hFFFF) seconds <= seconds + 16'h0001;
      end else begin
        tick_reg <= tick_reg + 32'h0000_0001;
      end
    end
  end
endmodule

// file: hw/prs_ramp_gen.sv
`timescale 1ns/10ps
`include "prs_map.svh"
// Frequency ramp: steps the output by one unit each time its step counter runs out.
module prs_ramp_gen import prs_pkg::*; #(
  parameter int CYC_PER_SEC = `PRS_CYC_PER_SEC
) (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Target and rate.
  input  wire logic [15:0] target,
  input  wire logic [31:0] step_cyc,
  input  wire logic        jump_down,
  // Ramp output.
  output logic [15:0]      freq
);
  initial begin
    if (CYC_PER_SEC < 2) $error("CYC_PER_SEC too small");
  end

  logic [31:0] cnt_reg;

  // One frequency unit per step period toward the target; an immediate drop to a lower target on jump_down.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_reg <= 32'h0000_0000;
      freq    <= 16'h0000;
    end else if (jump_down && (target < freq)) begin
      cnt_reg <= 32'h0000_0000;
      freq    <= target;
    end else if (freq == target) begin
      cnt_reg <= 32'h0000_0000;
    end else if (cnt_reg + 32'h0000_0001 >= step_cyc) begin
      cnt_reg <= 32'h0000_0000;
      freq    <= (target > freq) ? freq + 16'h0001 : freq - 16'h0001;
    end else begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
    end
  end
endmodule

// file: hw/prs_pump_ctrl.sv
`timescale 1ns/10ps
`include "prs_map.svh"
// Functional notes
// - Ramp time means minimum-to-maximum frequency travel, both directions; the code spans zero to maximum when not submersible.
// - Start-up ramp time resets to twelve seconds.
// - Shut-down ramp unused while freewheel halt select is NO.
// - Submersible: reach minimum within one second, maximum at twelve seconds total.
// - Not submersible: linear ramp from zero to maximum in twelve seconds.
// - Reset sets submersible option YES and minimum frequency thirty hertz.
// - Volts-per-hertz is the default control method.
// - Torque limit applies both directions; speed is lowered to respect it.
// - Flux reference scaled by user factor from ten to two hundred percent.
// - Sleep needs all three conditions; first, pressure at setpoint. The code's force-level stop from RUN enters SLEEP without the third.
// - Second: frequency below min plus offset, or pressure above force level.
// - Third: run time since restart exceeds selected minimum on-time.
// - Before sleeping raise target by the pre-doze amount, then stop.
// - While asleep, restart when pressure falls to setpoint minus wake threshold.
// - Stop when pressure reaches setpoint plus force offset, default twenty psi.
// - Time each motor-off period and compare it with off-time reference.
// - Long off uses long minimum run time, otherwise short.
module prs_pump_ctrl import prs_pkg::*; #(
  parameter int CYC_PER_SEC = `PRS_CYC_PER_SEC
) (
  // Clock and reset.
  input  wire logic            clk_sys,
  input  wire logic            reset,
  // Register port.
  input  wire prs_bus_req_type bus_req,
  output logic [15:0]          bus_rdata,
  // Sensor inputs.
  input  wire logic [15:0]     pressure_in,
  input  wire logic            torque_over_in,
  // Drive outputs.
  output prs_drive_type        drive_out,
  output logic                 motor_run
);
  initial begin
    if (CYC_PER_SEC < 2) $error("CYC_PER_SEC too small");
  end

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [15:0] press_s1_reg;
  logic [15:0] press_reg;
  logic        tq_s1_reg;
  logic        tq_reg;

  // Two stages for the transducer word and the torque flag; the word is slow moving.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      press_s1_reg <= 16'h0000;
      press_reg    <= 16'h0000;
      tq_s1_reg    <= 1'b0;
      tq_reg       <= 1'b0;
    end else begin
      press_s1_reg <= pressure_in;
      press_reg    <= press_s1_reg;
      tq_s1_reg    <= torque_over_in;
      tq_reg       <= tq_s1_reg;
    end
  end

  // ****************************************
  // Parameter registers
  // ****************************************
  logic [15:0] ctrl_reg;
  logic [15:0] accel_duration_reg;
  logic [15:0] decel_duration_reg;
  logic [15:0] minfreq_reg;
  logic [15:0] maxfreq_reg;
  logic [15:0] setpoint_reg;
  logic [15:0] sleepofs_reg;
  logic [15:0] forceofs_reg;
  logic [15:0] wakethr_reg;
  logic [15:0] pre_doze_raise_reg;
  logic [15:0] toff_reg;
  logic [15:0] long_min_run_time_reg;
  logic [15:0] short_min_run_time_reg;
  logic [15:0] torque_reg;
  logic [15:0] flux_reg;
  logic [15:0] flux_next;

  // Flux factor writes are clamped into the legal band.
  always_comb begin
    flux_next = bus_req.wdata;
    if (bus_req.wdata < `PRS_FLUX_MIN) flux_next = `PRS_FLUX_MIN;
    if (bus_req.wdata > `PRS_FLUX_MAX) flux_next = `PRS_FLUX_MAX;
  end

  // Keypad parameter writes.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl_reg               <= `PRS_RST_CTRL;
      accel_duration_reg     <= `PRS_RST_ACCEL_S;
      decel_duration_reg     <= `PRS_RST_ACCEL_S;
      minfreq_reg            <= `PRS_RST_MINFREQ;
      maxfreq_reg            <= `PRS_RST_MAXFREQ;
      setpoint_reg           <= `PRS_RST_SETPOINT;
      sleepofs_reg           <= `PRS_RST_SLEEPOFS;
      forceofs_reg           <= `PRS_RST_FORCEOFS;
      wakethr_reg            <= `PRS_RST_WAKETHR;
      pre_doze_raise_reg     <= `PRS_RST_RAISE;
      toff_reg               <= `PRS_RST_TOFF;
      long_min_run_time_reg  <= `PRS_RST_LONGON;
      short_min_run_time_reg <= `PRS_RST_SHORTON;
      torque_reg             <= `PRS_RST_TORQUE;
      flux_reg               <= `PRS_RST_FLUX;
    end else if (bus_req.wr) begin
      unique case (bus_req.addr)
        `PRS_ADDR_CTRL:     ctrl_reg               <= bus_req.wdata;
        `PRS_ADDR_ACCEL:    accel_duration_reg     <= bus_req.wdata;
        `PRS_ADDR_DECEL:    decel_duration_reg     <= bus_req.wdata;
        `PRS_ADDR_MINFREQ:  minfreq_reg            <= bus_req.wdata;
        `PRS_ADDR_MAXFREQ:  maxfreq_reg            <= bus_req.wdata;
        `PRS_ADDR_SETPOINT: setpoint_reg           <= bus_req.wdata;
        `PRS_ADDR_SLEEPOFS: sleepofs_reg           <= bus_req.wdata;
        `PRS_ADDR_FORCEOFS: forceofs_reg           <= bus_req.wdata;
        `PRS_ADDR_WAKETHR:  wakethr_reg            <= bus_req.wdata;
        `PRS_ADDR_RAISE:    pre_doze_raise_reg     <= bus_req.wdata;
        `PRS_ADDR_TOFF:     toff_reg               <= bus_req.wdata;
        `PRS_ADDR_LONGON:   long_min_run_time_reg  <= bus_req.wdata;
        `PRS_ADDR_SHORTON:  short_min_run_time_reg <= bus_req.wdata;
        `PRS_ADDR_TORQUE:   torque_reg             <= bus_req.wdata;
        `PRS_ADDR_FLUX:     flux_reg               <= flux_next;
        default: ;
      endcase
    end
  end

  wire logic submersible   = ctrl_reg[`PRS_CTRL_SUBMERSIBLE];
  wire logic freewheel_sel = ctrl_reg[`PRS_CTRL_FREEWHEEL];
  wire logic run_cmd       = ctrl_reg[`PRS_CTRL_RUN];

  // ****************************************
  // Sleep and wake sequencing
  // ****************************************
  prs_state_type state_reg;
  logic [15:0]   on_secs;
  logic [15:0]   off_secs;
  logic          long_off_reg;
  logic [15:0]   freq_now;
  logic [15:0]   press_target;
  logic          sleep_ok;
  logic          cond_at_sp;
  logic          cond_low;
  logic          cond_force;
  logic          cond_time;
  logic [15:0]   min_on;
  logic          start_pulse;

  // Minimum on-time follows the length of the last off period.
  assign min_on     = long_off_reg ? long_min_run_time_reg : short_min_run_time_reg;
  assign cond_at_sp = press_reg >= setpoint_reg;
  assign cond_force = press_reg >= setpoint_reg + forceofs_reg;
  assign cond_low   = freq_now < minfreq_reg + sleepofs_reg;
  assign cond_time  = on_secs > min_on;
  // Force level implies the setpoint was reached, so sleep_ok needs all three; the RUN force stop to SLEEP does not wait on cond_time.
  assign sleep_ok   = cond_at_sp && (cond_low || cond_force) && cond_time;
  assign start_pulse = (state_reg == PRS_ST_STOP && run_cmd) ||
                       (state_reg == PRS_ST_SLEEP &&
                        press_reg <= setpoint_reg - wakethr_reg);

  // Pump state: the boost step lifts the target before the motor stops.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg <= PRS_ST_STOP;
    end else if (!run_cmd) begin
      state_reg <= PRS_ST_STOP;
    end else begin
      unique case (state_reg)
        PRS_ST_STOP:  state_reg <= PRS_ST_RUN;
        PRS_ST_RUN:   if (cond_force) state_reg <= PRS_ST_SLEEP;
                      else if (sleep_ok) state_reg <= PRS_ST_BOOST;
        PRS_ST_BOOST: if (press_reg >= setpoint_reg + pre_doze_raise_reg || cond_force)
                        state_reg <= PRS_ST_SLEEP;
        PRS_ST_SLEEP: if (start_pulse) state_reg <= PRS_ST_RUN;
      endcase
    end
  end

  // Target raised by the pre-doze amount during the boost step.
  assign press_target = (state_reg == PRS_ST_BOOST) ?
                        setpoint_reg + pre_doze_raise_reg : setpoint_reg;

  // Latch whether the off period just ended was long.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      long_off_reg <= 1'b1;
    end else if (state_reg == PRS_ST_SLEEP && start_pulse) begin
      long_off_reg <= off_secs > toff_reg;
    end
  end

  // On timer restarts at each start, off timer at each sleep entry.
  prs_sec_timer #(.CYC_PER_SEC(CYC_PER_SEC)) u_on_tmr (
    .clk_sys (clk_sys),
    .reset   (reset),
    .restart (start_pulse),
    .enable  (state_reg == PRS_ST_RUN),
    .seconds (on_secs)
  );
  prs_sec_timer #(.CYC_PER_SEC(CYC_PER_SEC)) u_off_tmr (
    .clk_sys (clk_sys),
    .reset   (reset),
    .restart (state_reg != PRS_ST_SLEEP),
    .enable  (1'b1),
    .seconds (off_secs)
  );

  // ****************************************
  // Ramp profile
  // ****************************************
  logic [15:0] ramp_target;
  logic [31:0] step_cyc;
  logic [15:0] span;
  logic [15:0] min_eff;
  logic        motor_on;
  logic        below_min;
  logic [31:0] fast_cyc;
  logic [31:0] slope_cyc;
  logic [47:0] slope_wide;
  logic [47:0] fast_wide;
  logic [47:0] decel_wide;
  logic [15:0] accel_eff;

  assign motor_on  = (state_reg == PRS_ST_RUN) || (state_reg == PRS_ST_BOOST);
  assign min_eff   = submersible ? minfreq_reg : 16'h0000;
  assign span      = (maxfreq_reg > min_eff) ? maxfreq_reg - min_eff : 16'h0001;
  assign below_min = freq_now < minfreq_reg;
  // Submersible start spends one second of the budget on the fast climb.
  assign accel_eff = (submersible && accel_duration_reg > 16'h0001) ?
                     accel_duration_reg - 16'h0001 : accel_duration_reg;
  assign slope_wide = (48'(accel_eff) * 48'(CYC_PER_SEC)) / 48'(span);
  assign fast_wide  = 48'(`PRS_FAST_CLIMB_CYC) /
                      48'((minfreq_reg == 16'h0000) ? 16'h0001 : minfreq_reg);
  // The stop ramp has its own rate over the same span; sharing the start slope would
  // leave the shut-down time setting with no effect.
  assign decel_wide = (48'(decel_duration_reg) * 48'(CYC_PER_SEC)) / 48'(span);
  assign slope_cyc = slope_wide[31:0];
  assign fast_cyc  = fast_wide[31:0];

  // Target and step period; the torque flag holds speed down to respect the limit.
  always_comb begin
    ramp_target = motor_on ? maxfreq_reg : 16'h0000;
    if (motor_on && tq_reg && freq_now > min_eff)
      ramp_target = freq_now - 16'h0001;
    if (!motor_on)
      step_cyc = (decel_wide > 48'h0000_FFFF_FFFF) ? 32'hFFFF_FFFF : decel_wide[31:0];
    else if (submersible && below_min)
      step_cyc = fast_cyc;
    else
      step_cyc = slope_cyc;
  end

  // Without freewheel the decel ramp is bypassed and the output drops at once.
  prs_ramp_gen #(.CYC_PER_SEC(CYC_PER_SEC)) u_ramp (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .target    (ramp_target),
    .step_cyc  (step_cyc),
    .jump_down (!motor_on && !freewheel_sel),
    .freq      (freq_now)
  );

  // ****************************************
  // Drive outputs
  // ****************************************
  // Torque limit is symmetric; the flux factor goes out as a scale percentage.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      drive_out <= '0;
      motor_run <= 1'b0;
    end else begin
      drive_out.freq_cmd    <= freq_now;
      drive_out.torque_lim  <= torque_reg;
      drive_out.flux_scale  <= flux_reg;
      drive_out.vector_mode <= ctrl_reg[`PRS_CTRL_VECTOR];
      motor_run             <= motor_on;
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  // Read data appear one cycle after the strobe, zero otherwise and for unmapped addresses.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      bus_rdata <= 16'h0000;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        `PRS_ADDR_CTRL:     bus_rdata <= ctrl_reg;
        `PRS_ADDR_ACCEL:    bus_rdata <= accel_duration_reg;
        `PRS_ADDR_DECEL:    bus_rdata <= decel_duration_reg;
        `PRS_ADDR_MINFREQ:  bus_rdata <= minfreq_reg;
        `PRS_ADDR_MAXFREQ:  bus_rdata <= maxfreq_reg;
        `PRS_ADDR_SETPOINT: bus_rdata <= setpoint_reg;
        `PRS_ADDR_SLEEPOFS: bus_rdata <= sleepofs_reg;
        `PRS_ADDR_FORCEOFS: bus_rdata <= forceofs_reg;
        `PRS_ADDR_WAKETHR:  bus_rdata <= wakethr_reg;
        `PRS_ADDR_RAISE:    bus_rdata <= pre_doze_raise_reg;
        `PRS_ADDR_TOFF:     bus_rdata <= toff_reg;
        `PRS_ADDR_LONGON:   bus_rdata <= long_min_run_time_reg;
        `PRS_ADDR_SHORTON:  bus_rdata <= short_min_run_time_reg;
        `PRS_ADDR_TORQUE:   bus_rdata <= torque_reg;
        `PRS_ADDR_FLUX:     bus_rdata <= flux_reg;
        `PRS_ADDR_STATUS:   bus_rdata <= {13'h0000, long_off_reg, state_reg};
        `PRS_ADDR_FREQ:     bus_rdata <= freq_now;
        `PRS_ADDR_TARGET:   bus_rdata <= press_target;
        default:            bus_rdata <= 16'h0000;
      endcase
    end else begin
      bus_rdata <= 16'h0000;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_flux_band: assert property (@(posedge clk_sys) disable iff (reset)
    flux_reg >= `PRS_FLUX_MIN && flux_reg <= `PRS_FLUX_MAX)
    else $error("flux factor out of band");
  a_boost_first: assert property (@(posedge clk_sys) disable iff (reset)
    (state_reg == PRS_ST_RUN && sleep_ok && !cond_force && run_cmd) |=> state_reg == PRS_ST_BOOST)
    else $error("sleep skipped boost");
  a_force_stop: assert property (@(posedge clk_sys) disable iff (reset)
    (state_reg == PRS_ST_RUN && cond_force && run_cmd) |=> state_reg == PRS_ST_SLEEP)
    else $error("force level ignored");
  a_wake_up: assert property (@(posedge clk_sys) disable iff (reset)
    (state_reg == PRS_ST_SLEEP && start_pulse && run_cmd) |=> state_reg == PRS_ST_RUN)
    else $error("wake missed");
  a_sleep_conds: assert property (@(posedge clk_sys) disable iff (reset)
    (state_reg == PRS_ST_RUN ##1 state_reg == PRS_ST_BOOST) |-> $past(cond_at_sp && cond_time))
    else $error("sleep without conditions");
  a_min_on_sel: assert property (@(posedge clk_sys) disable iff (reset)
    (state_reg == PRS_ST_RUN ##1 state_reg == PRS_ST_BOOST) |->
      $past(on_secs) > $past(long_off_reg ? long_min_run_time_reg : short_min_run_time_reg))
    else $error("wrong minimum on-time");
  a_on_clear: assert property (@(posedge clk_sys) disable iff (reset)
    start_pulse |=> on_secs == 16'h0000)
    else $error("on timer not cleared");
  a_drop_fast: assert property (@(posedge clk_sys) disable iff (reset)
    (!motor_on && !freewheel_sel && run_cmd) |=> ##1 freq_now == 16'h0000)
    else $error("stop ramp used without freewheel");
  c_boost: cover property (@(posedge clk_sys) disable iff (reset) state_reg == PRS_ST_BOOST);
  c_sleep: cover property (@(posedge clk_sys) disable iff (reset) state_reg == PRS_ST_SLEEP);
  c_wake: cover property (@(posedge clk_sys) disable iff (reset)
    state_reg == PRS_ST_SLEEP ##1 state_reg == PRS_ST_RUN);
endmodule

// file: bench/prs_tank_model.sv
`timescale 1ns/10ps
// ****************
// Tank and transducer
// ****************
module prs_tank_model (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Pump state and transducer reading.
  input  wire logic        motor_run,
  output logic [15:0]      pressure
);
  logic [5:0] tick_reg;

  // One psi per 64 cycles, so the reading moves far slower than the input sync.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tick_reg <= 6'h00;
      pressure <= 16'h0000;
    end else begin
      tick_reg <= tick_reg + 6'h01;
      if (tick_reg == 6'h3F && motor_run) begin
        pressure <= pressure + 16'h0001;
      end else if (tick_reg == 6'h3F && pressure != 16'h0000) begin
        pressure <= pressure - 16'h0001; // Tank bleeds off while stopped.
      end
    end
  end
endmodule

// file: bench/test_pump_ramp_sleep_control.sv
`timescale 1ns/10ps
`include "prs_map.svh"
module test_pump_ramp_sleep_control import prs_pkg::*; ;
  logic            clk_sys = 1'b0;
  logic            reset = 1'b1;
  prs_bus_req_type bus_req;
  logic [15:0]     bus_rdata;
  logic [15:0]     pressure_in;
  logic [15:0]     rd_val;
  logic            torque_over_in;
  prs_drive_type   drive_out;
  logic            motor_run;
  int              fail_count = 0;
  int              comparisons = 0;
  int              cyc = 0;
  int              t0;
  logic [15:0]     exp_rst [15] = '{16'h0001, 16'h000C, 16'h000C, 16'h012C, 16'h0258,
    16'h0032, 16'h0000, 16'h0014, 16'h0005, 16'h0005, 16'h003C, 16'h003C, 16'h000A,
    16'h0064, 16'h0064};

  // ****************
  // Harness
  // ****************
  // Time is shortened to 100 cycles a second so the sleep cycle fits the run.
  prs_pump_ctrl #(.CYC_PER_SEC(100)) prs_pump_ctrl_i (.clk_sys(clk_sys), .reset(reset),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .pressure_in(pressure_in),
    .torque_over_in(torque_over_in), .drive_out(drive_out), .motor_run(motor_run));
  prs_tank_model prs_tank_model_i (.clk_sys(clk_sys), .reset(reset),
    .motor_run(motor_run), .pressure(pressure_in));

  // Clock and hang limit; the tests need roughly 9000 cycles.
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      test_done();
    end
  end

  // ****************
  // Tasks
  // ****************
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rng(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi,
                     input string what);
    chk({15'h0000, v >= lo && v <= hi}, 16'h0001, what);
  endtask

  // Each strobe starts one edge after the last one fell, so no signal is set twice at once.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe edge.
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1 rd_val = bus_rdata;
  endtask

  task automatic wait_run(input logic v);
    int n;
    n = 0;
    while (motor_run !== v && n < 20000) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk({15'h0000, motor_run}, {15'h0000, v}, "pump state");
  endtask

  // ****************
  // Sequence
  // ****************
  initial begin
    bus_req = '0;
    torque_over_in = 1'b0;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    for (int a = 0; a < 15; a++) begin
      rd(8'(a));
      chk(rd_val, exp_rst[a], "reset value");
    end
    chk({15'h0000, drive_out.vector_mode}, 16'h0000, "control method");
    // Flux writes outside the legal span are clamped to its ends.
    wr(`PRS_ADDR_FLUX, 16'h0005);
    rd(`PRS_ADDR_FLUX);
    chk(rd_val, 16'h000A, "flux low clamp");
    wr(`PRS_ADDR_FLUX, 16'h00FA);
    rd(`PRS_ADDR_FLUX);
    chk(drive_out.flux_scale, 16'h00C8, "flux high clamp");
    wr(`PRS_ADDR_TORQUE, 16'h0096);
    rd(8'h0F);
    chk(drive_out.torque_lim, 16'h0096, "torque limit");
    chk(rd_val, 16'h0000, "unmapped read");
    // Linear start, no fast climb: 600 units in 1200 cycles.
    wr(`PRS_ADDR_LONGON, 16'h0003);
    wr(`PRS_ADDR_SHORTON, 16'h0003);
    wr(`PRS_ADDR_CTRL, 16'h0008);
    repeat (600) @(posedge clk_sys);
    #1 rng(drive_out.freq_cmd, 16'h0122, 16'h0136, "ramp midpoint");
    repeat (650) @(posedge clk_sys);
    #1 chk(drive_out.freq_cmd, 16'h0258, "ramp end");
    @(posedge clk_sys);
    torque_over_in <= 1'b1;
    repeat (40) @(posedge clk_sys);
    torque_over_in <= 1'b0;
    #1 rng(drive_out.freq_cmd, 16'h0000, 16'h0257, "torque back-off");
    // Force level: 50 + 20 psi stops the pump and drops frequency at once.
    wait_run(1'b0);
    rng(pressure_in, 16'h0046, 16'h0047, "force sleep level");
    @(posedge clk_sys);
    #1 chk(drive_out.freq_cmd, 16'h0000, "no decel ramp");
    rd(`PRS_ADDR_STATUS);
    chk(rd_val & 16'h0003, 16'h0002, "asleep");
    // Off time near 16 s is under the 20 s reference, so the 15 s short minimum applies.
    // Whole seconds compared strictly put the boost at 16 s of run time.
    wr(`PRS_ADDR_TOFF, 16'h0014);
    wr(`PRS_ADDR_LONGON, 16'h0028);
    wr(`PRS_ADDR_SHORTON, 16'h000F);
    wr(`PRS_ADDR_SLEEPOFS, 16'h0190);
    wr(`PRS_ADDR_FORCEOFS, 16'h0064);
    wr(`PRS_ADDR_RAISE, 16'h001E);
    wait_run(1'b1);
    rng(pressure_in, 16'h002C, 16'h002D, "wake level");
    t0 = cyc;
    rd_val = 16'h0000;
    while (rd_val[1:0] !== 2'b11 && cyc - t0 < 6000) begin
      rd(`PRS_ADDR_STATUS);
    end
    rng(16'(cyc - t0), 16'h0640, 16'h065E, "minimum run");
    chk({15'h0000, rd_val[2]}, 16'h0000, "short off");
    rd(`PRS_ADDR_TARGET);
    chk(rd_val, 16'h0050, "raised target");
    wait_run(1'b0);
    rng(pressure_in, 16'h0050, 16'h0051, "stop after raise");
    // Freewheel stop follows the 24 s shut-down ramp, four cycles a unit, not a drop.
    wr(`PRS_ADDR_DECEL, 16'h0018);
    wr(`PRS_ADDR_SETPOINT, 16'h0064);
    repeat (400) @(posedge clk_sys);
    wr(`PRS_ADDR_CTRL, 16'h0006);
    repeat (100) @(posedge clk_sys);
    #1 rng(drive_out.freq_cmd, 16'h00AA, 16'h00B6, "decel ramp");
    chk({15'h0000, drive_out.vector_mode}, 16'h0001, "vector select");
    test_done();
  end
endmodule
